// File: rtl/sarc_pkg.sv
// Package holding register map, field layout and timing constants for the converter control.
package sarc_pkg;

	// Register offsets, chosen for the plain register port.
	localparam logic [2:0] ADDR_RESULT_LOW  = 3'h0;
	localparam logic [2:0] ADDR_RESULT_HIGH = 3'h1;
	localparam logic [2:0] ADDR_CTRL_START  = 3'h2;
	localparam logic [2:0] ADDR_SRC_CLK_SEL = 3'h3;
	localparam logic [2:0] ADDR_BANDGAP     = 3'h4;

	// Field positions in the control/start register.
	localparam int CTRL_START_POS  = 7;
	localparam int CTRL_BUSY_POS   = 6;
	localparam int CTRL_ENABLE_POS = 5;
	localparam int CTRL_ALIGN_POS  = 4;

	// Field positions in the source/clock select register.
	localparam int SRC_SEL_LSB = 5;
	localparam int REF_SEL_LSB = 3;
	localparam int CLK_SEL_LSB = 0;

	// Reset values.
	localparam logic [7:0] CTRL_START_RESET = 8'h00;
	localparam logic [7:0] SRC_CLK_RESET    = 8'h00;
	localparam logic       BANDGAP_RESET    = 1'b0;

	// Conversion timing in conversion clock cycles.
	localparam int SAMPLE_CYCLES  = 4;
	localparam int CONVERT_CYCLES = 10;
	localparam int TOTAL_CYCLES   = SAMPLE_CYCLES + CONVERT_CYCLES;

	// Channel codes and source codes.
	localparam logic [3:0] CHAN_LAST_PIN  = 4'h2;
	localparam logic [2:0] SRC_BANDGAP    = 3'h1;
	localparam logic [2:0] SRC_OPAMP_ZERO = 3'h2;
	localparam logic [2:0] SRC_OPAMP_ONE  = 3'h3;
	localparam logic [2:0] SRC_GROUND     = 3'h4;
	localparam logic [1:0] REF_SUPPLY     = 2'h1;

	// Register port request.
	typedef struct packed {
		logic [2:0] addr;
		logic [7:0] wdata;
		logic       wr;
		logic       rd;
	} sarc_req_t;

	// Analog routing controls toward the converter core.
	typedef struct packed {
		logic       power_on;
		logic [2:0] pin_select;
		logic       pin_none;
		logic       use_bandgap;
		logic       use_opamp_zero;
		logic       use_opamp_one;
		logic       use_ground;
		logic       use_supply_ref;
		logic       bandgap_on;
	} sarc_route_t;

	// Conversion progress states.
	typedef enum logic [2:0] {
		ST_IDLE   = 3'b001,
		ST_SAMPLE = 3'b010,
		ST_CONV   = 3'b100
	} sarc_state_t;

endpackage : sarc_pkg

// File: rtl/sarc_ctrl.sv
// Register file and sequencer controlling a 10-bit successive-approximation converter.
// How it works
// - Start pulse high then low begins conversion
// - Busy set at start, cleared at completion
// - Busy flag ignores software writes
// - Enable powers converter; disabled keeps results
// - Align zero: high D9..D2, low D1..D0
// - Align one: high D9..D8, low D7..D0
// - Unused result bits read as zero
// - Every conversion yields a 10-bit result
// - Channel codes 0..2 pick pins, others float
// - Source 000,101,110,111 routes external channel
// - Sources 001..100: bandgap, opamps, ground
// - Reference 01 supply, else external pin
// - Conversion clock is system clock over 2^field
// - Bandgap enable on; off means output floats
// - Bandgap register bits 7..1 read zero
// - Selected analog pin drops digital function, pull-high
// - Result registers are read-only
// - Conversion takes 4 sample plus 10 convert
// - Completion raises converter interrupt request pulse
//
// Decided for this implementation: the address map and the plain strobed port.
`timescale 1ns/1ps

module sarc_ctrl #(
	parameter int RESULT_WIDTH = 10
) (
	input  wire logic                 i_ref_clk,
	input  wire logic                 i_sys_rst,
	input  wire sarc_pkg::sarc_req_t  i_req,
	output logic [7:0]                o_rdata,
	input  wire logic                 i_bit_value,
	output logic                      o_sample,
	output logic                      o_trial_strobe,
	output logic [3:0]                o_trial_index,
	output sarc_pkg::sarc_route_t     o_route,
	output logic [2:0]                o_pin_analog,
	output logic                      o_busy,
	output logic                      o_conv_done
);
	import sarc_pkg::*;

	initial begin
		if (RESULT_WIDTH != 10) begin
			$error("Result layout only serves a width of ten bits.");
		end
	end

	logic [7:0]        ctrl_reg;
	logic [7:0]        src_clk_reg;
	logic              bandgap_en;
	logic              busy;
	logic              start_seen;
	logic [9:0]        result;
	logic [9:0]        shift_acc;
	logic [6:0]        div_cnt;
	logic              conv_tick;
	logic [3:0]        cyc_cnt;
	logic              start_req;
	logic              bit_sync_a;
	logic              bit_sync_b;
	sarc_state_t       state;
	logic [7:0]        result_high;
	logic [7:0]        result_low;
	logic [2:0]        src_sel;
	logic [3:0]        chan_sel;
	logic [2:0]        clk_sel;
	logic              pin_route;

	assign src_sel  = src_clk_reg[SRC_SEL_LSB +: 3];
	assign clk_sel  = src_clk_reg[CLK_SEL_LSB +: 3];
	assign chan_sel = ctrl_reg[3:0];

	// Control register writes; the busy bit position is never stored from the bus.
	always_ff @(posedge i_ref_clk) begin
		if (i_sys_rst) begin
			ctrl_reg    <= CTRL_START_RESET;
			src_clk_reg <= SRC_CLK_RESET;
			bandgap_en  <= BANDGAP_RESET;
		end else if (i_req.wr) begin
			case (i_req.addr)
				ADDR_CTRL_START:  ctrl_reg    <= {i_req.wdata[7], 1'b0, i_req.wdata[5:0]};
				ADDR_SRC_CLK_SEL: src_clk_reg <= i_req.wdata;
				ADDR_BANDGAP:     bandgap_en  <= i_req.wdata[0];
				default:          ctrl_reg    <= ctrl_reg;
			endcase
		end
	end

	// Start request: the start bit written low after having been high.
	assign start_req = i_req.wr && (i_req.addr == ADDR_CTRL_START)
		&& ctrl_reg[CTRL_START_POS] && !i_req.wdata[CTRL_START_POS];

	// Remember a start attempt that arrived while the converter was off or busy is dropped.
	always_ff @(posedge i_ref_clk) begin
		if (i_sys_rst) begin
			start_seen <= 1'b0;
		end else begin
			start_seen <= start_req && !busy && ctrl_reg[CTRL_ENABLE_POS];
		end
	end

	// Conversion clock divider: a tick every 2^clk_sel system cycles.
	always_ff @(posedge i_ref_clk) begin
		if (i_sys_rst || !busy) begin
			div_cnt <= 7'h00;
		end else if (conv_tick) begin
			div_cnt <= 7'h00;
		end else begin
			div_cnt <= div_cnt + 7'h01;
		end
	end
	assign conv_tick = busy && (div_cnt == 7'((8'h01 << clk_sel) - 8'h01));

	// The comparator answer comes from the analog core, so it is synchronised.
	always_ff @(posedge i_ref_clk) begin
		if (i_sys_rst) begin
			bit_sync_a <= 1'b0;
			bit_sync_b <= 1'b0;
		end else begin
			bit_sync_a <= i_bit_value;
			bit_sync_b <= bit_sync_a;
		end
	end

	// Sequencer: sampling then ten bit trials, MSB first.
	always_ff @(posedge i_ref_clk) begin
		if (i_sys_rst) begin
			state     <= ST_IDLE;
			busy      <= 1'b0;
			cyc_cnt   <= 4'h0;
			shift_acc <= 10'h000;
		end else begin
			case (state)
				ST_IDLE: begin
					if (start_seen) begin
						state   <= ST_SAMPLE;
						busy    <= 1'b1;
						cyc_cnt <= 4'h0;
					end
				end
				ST_SAMPLE: begin
					if (conv_tick) begin
						if (cyc_cnt == 4'(SAMPLE_CYCLES - 1)) begin
							state   <= ST_CONV;
							cyc_cnt <= 4'h0;
						end else begin
							cyc_cnt <= cyc_cnt + 4'h1;
						end
					end
				end
				ST_CONV: begin
					if (conv_tick) begin
						shift_acc <= {shift_acc[8:0], bit_sync_b};
						if (cyc_cnt == 4'(CONVERT_CYCLES - 1)) begin
							state <= ST_IDLE;
							busy  <= 1'b0;
						end else begin
							cyc_cnt <= cyc_cnt + 4'h1;
						end
					end
				end
				default: begin
					state <= ST_IDLE;
					busy  <= 1'b0;
				end
			endcase
			if (!ctrl_reg[CTRL_ENABLE_POS]) begin
				state <= ST_IDLE;
				busy  <= 1'b0;
			end
		end
	end

	// Completion pulse toward the interrupt controller.
	assign o_conv_done = (state == ST_CONV) && conv_tick
		&& (cyc_cnt == 4'(CONVERT_CYCLES - 1)) && ctrl_reg[CTRL_ENABLE_POS];

	// Whole result loaded in one edge, so readers never see a torn value.
	always_ff @(posedge i_ref_clk) begin
		if (i_sys_rst) begin
			result <= 10'h000;
		end else if (o_conv_done) begin
			result <= {shift_acc[8:0], bit_sync_b};
		end
	end

	// Alignment of the stored result into the two read-only bytes.
	always_comb begin
		if (ctrl_reg[CTRL_ALIGN_POS]) begin
			result_high = {6'h00, result[9:8]};
			result_low  = result[7:0];
		end else begin
			result_high = result[9:2];
			result_low  = {result[1:0], 6'h00};
		end
	end

	// Read data stands in the cycle after the read strobe.
	always_ff @(posedge i_ref_clk) begin
		if (i_sys_rst) begin
			o_rdata <= 8'h00;
		end else if (i_req.rd) begin
			case (i_req.addr)
				ADDR_RESULT_LOW:  o_rdata <= result_low;
				ADDR_RESULT_HIGH: o_rdata <= result_high;
				ADDR_CTRL_START:  o_rdata <= {ctrl_reg[7], busy, ctrl_reg[5:0]};
				ADDR_SRC_CLK_SEL: o_rdata <= src_clk_reg;
				ADDR_BANDGAP:     o_rdata <= {7'h00, bandgap_en};
				default:          o_rdata <= 8'h00;
			endcase
		end else begin
			o_rdata <= 8'h00;
		end
	end

	// Analog routing decode.
	// Every code outside the four internal sources routes the external channel.
	assign pin_route = !(src_sel inside {SRC_BANDGAP, SRC_OPAMP_ZERO,
		SRC_OPAMP_ONE, SRC_GROUND});
	always_comb begin
		o_route                = '0;
		o_route.power_on       = ctrl_reg[CTRL_ENABLE_POS];
		o_route.pin_none       = (chan_sel > CHAN_LAST_PIN) || !pin_route;
		o_route.pin_select     = 3'h0;
		if (pin_route && chan_sel <= CHAN_LAST_PIN) begin
			o_route.pin_select = 3'(3'h1 << chan_sel[1:0]);
		end
		o_route.use_bandgap    = (src_sel == SRC_BANDGAP);
		o_route.use_opamp_zero = (src_sel == SRC_OPAMP_ZERO);
		o_route.use_opamp_one  = (src_sel == SRC_OPAMP_ONE);
		o_route.use_ground     = (src_sel == SRC_GROUND);
		o_route.use_supply_ref = (src_clk_reg[REF_SEL_LSB +: 2] == REF_SUPPLY);
		o_route.bandgap_on     = bandgap_en;
	end

	// A pin taken as analog input loses digital function and pull-high.
	assign o_pin_analog   = o_route.pin_select;
	assign o_busy         = busy;
	assign o_sample       = (state == ST_SAMPLE);
	assign o_trial_strobe = (state == ST_CONV) && conv_tick;
	assign o_trial_index  = cyc_cnt;

endmodule : sarc_ctrl

// File: verif/sarc_ctrl_monitor.sv
// Port checker for the converter control block.
`timescale 1ns/1ps
module sarc_ctrl_monitor
	import sarc_pkg::*;
(
	input wire logic                i_ref_clk,
	input wire logic                i_sys_rst,
	input wire sarc_pkg::sarc_req_t i_req,
	input wire logic [7:0]          o_rdata,
	input wire logic                o_busy,
	input wire logic                o_conv_done,
	input wire sarc_pkg::sarc_route_t o_route
);
	logic [7:0] sh_ctrl;
	logic [7:0] sh_src;
	logic       sh_bg;

	// Shadow copies of written bits, so routing can be judged from the bus alone.
	always_ff @(posedge i_ref_clk) begin
		if (i_sys_rst) begin
			sh_ctrl <= 8'h00;
			sh_src <= 8'h00;
			sh_bg <= 1'b0;
		end else if (i_req.wr) begin
			if (i_req.addr == ADDR_CTRL_START) sh_ctrl <= i_req.wdata;
			if (i_req.addr == ADDR_SRC_CLK_SEL) sh_src <= i_req.wdata;
			if (i_req.addr == ADDR_BANDGAP) sh_bg <= i_req.wdata[0];
		end
	end

	default clocking cb @(posedge i_ref_clk); endclocking
	default disable iff (i_sys_rst);

	property p_done_clr; o_conv_done |=> !o_busy; endproperty
	a_done_clr: assert property (p_done_clr) else $error("busy kept after done");
	property p_min_len; $rose(o_busy) |-> !o_conv_done [*8]; endproperty
	a_min_len: assert property (p_min_len) else $error("conversion too short");
	property p_start;
		$rose(o_busy) |-> $past(i_req.wr, 2) && !$past(i_req.wdata[7], 2)
			&& $past(i_req.addr, 2) == ADDR_CTRL_START;
	endproperty
	a_start: assert property (p_start) else $error("busy without start release");
	property p_fall; $fell(o_busy) |-> $past(o_conv_done) || !sh_ctrl[CTRL_ENABLE_POS]; endproperty
	a_fall: assert property (p_fall) else $error("busy cleared early");
	property p_bg_rd;
		$past(i_req.rd) && $past(i_req.addr) == ADDR_BANDGAP |-> o_rdata[7:1] == 7'h00;
	endproperty
	a_bg_rd: assert property (p_bg_rd) else $error("bandgap upper bits set");
	property p_ground; o_route.use_ground == (sh_src[7:5] == SRC_GROUND); endproperty
	a_ground: assert property (p_ground) else $error("ground routing wrong");
	property p_sup; o_route.use_supply_ref == (sh_src[4:3] == REF_SUPPLY); endproperty
	a_sup: assert property (p_sup) else $error("reference select wrong");
	property p_pwr; o_route.power_on == sh_ctrl[CTRL_ENABLE_POS]; endproperty
	a_pwr: assert property (p_pwr) else $error("power control wrong");
	property p_bg_on; o_route.bandgap_on == sh_bg; endproperty
	a_bg_on: assert property (p_bg_on) else $error("bandgap enable wrong");

	c_start: cover property ($rose(o_busy));
	c_done: cover property (o_conv_done);
	c_bg: cover property (i_req.rd && i_req.addr == ADDR_BANDGAP);
endmodule : sarc_ctrl_monitor

bind sarc_ctrl sarc_ctrl_monitor i_sarc_ctrl_monitor (
	.i_ref_clk(i_ref_clk), .i_sys_rst(i_sys_rst), .i_req(i_req), .o_rdata(o_rdata),
	.o_busy(o_busy), .o_conv_done(o_conv_done), .o_route(o_route));

// File: verif/sarc_ctrl_tb_top.sv
// Self-checking bench for the converter control block.
`timescale 1ns/1ps
module sarc_ctrl_tb_top;
	import sarc_pkg::*;
	logic        i_ref_clk = 1'b0;
	logic        i_sys_rst = 1'b1;
	sarc_req_t   i_req = '0;
	logic        i_bit_value = 1'b0;
	logic [7:0]  o_rdata;
	logic        o_sample, o_trial_strobe, o_busy, o_conv_done;
	logic [3:0]  o_trial_index;
	logic [2:0]  o_pin_analog;
	sarc_route_t o_route;
	int          miscompares = 0;
	int          checks_done = 0;
	int          cyc = 0;
	int          n;
	logic [7:0]  d;
	logic [15:0] e;

	sarc_ctrl i_sarc_ctrl (.i_ref_clk(i_ref_clk), .i_sys_rst(i_sys_rst), .i_req(i_req),
		.o_rdata(o_rdata), .i_bit_value(i_bit_value), .o_sample(o_sample),
		.o_trial_strobe(o_trial_strobe), .o_trial_index(o_trial_index), .o_route(o_route),
		.o_pin_analog(o_pin_analog), .o_busy(o_busy), .o_conv_done(o_conv_done));

	always #10 i_ref_clk = ~i_ref_clk;

	// Hang guard, well above the slowest conversion sweep.
	always @(posedge i_ref_clk) begin
		cyc <= cyc + 1;
		if (cyc == 20000) begin
			miscompares++;
			final_report();
		end
	end

	task automatic final_report();
		if (miscompares == 0 && checks_done > 0) begin
			$display("ALL TESTS PASSED");
		end else begin
			$display("TESTS FAILED");
		end
		$finish;
	endtask : final_report

	task automatic chk(input logic [7:0] got, input logic [7:0] exp);
		checks_done++;
		if (got !== exp) begin
			miscompares++;
			$display("ERROR %0t mismatch got %h exp %h", $time, got, exp);
		end
	endtask : chk

	task automatic wr(input logic [2:0] a, input logic [7:0] dat);
		@(posedge i_ref_clk);
		i_req <= '{a, dat, 1'b1, 1'b0};
		@(posedge i_ref_clk);
		i_req <= '0;
	endtask : wr

	// Read data stand only in the cycle after the strobe, so sample just past that edge.
	task automatic rd(input logic [2:0] a, input logic [7:0] exp);
		@(posedge i_ref_clk);
		i_req <= '{a, 8'h00, 1'b0, 1'b1};
		@(posedge i_ref_clk);
		i_req <= '0;
		#1;
		chk(o_rdata, exp);
	endtask : rd

	// A steady comparator answer makes every result bit equal to it.
	function automatic logic [15:0] res(input logic v, input logic al);
		return al ? {6'h00, {10{v}}} : {{10{v}}, 6'h00};
	endfunction : res

	task automatic conv(input int k, input logic al, input logic v);
		e = res(v, al);
		wr(ADDR_SRC_CLK_SEL, 8'(k));
		i_bit_value <= v;
		wr(ADDR_CTRL_START, {3'b101, al, 4'h0});
		wr(ADDR_CTRL_START, {3'b001, al, 4'h0});
		n = 0;
		while (o_busy !== 1'b1 && n < 8) begin
			@(posedge i_ref_clk);
			#1;
			n++;
		end
		chk({7'h00, o_sample}, 8'h01);
		chk({5'h00, o_pin_analog}, 8'h01);
		n = 0;
		while (o_busy === 1'b1 && n < 4000) begin
			@(posedge i_ref_clk);
			#1;
			n++;
		end
		chk(8'(n > (13 << k) && n <= (15 << k) + 4), 8'h01);
		rd(ADDR_RESULT_HIGH, e[15:8]);
		rd(ADDR_RESULT_LOW, e[7:0]);
	endtask : conv

	initial begin
		n = $urandom(46);
		repeat (10) @(posedge i_ref_clk);
		i_sys_rst <= 1'b0;
		rd(ADDR_CTRL_START, CTRL_START_RESET);
		rd(ADDR_SRC_CLK_SEL, SRC_CLK_RESET);
		rd(ADDR_BANDGAP, 8'h00);
		rd(3'h5, 8'h00);
		repeat (16) begin
			d = 8'($urandom);
			// Channel is parked on a floating code before any internal source is chosen.
			wr(ADDR_CTRL_START, (d & 8'h7F) | 8'h03);
			rd(ADDR_CTRL_START, (d & 8'h3F) | 8'h03);
			wr(ADDR_SRC_CLK_SEL, d);
			rd(ADDR_SRC_CLK_SEL, d);
			chk({5'h00, o_pin_analog}, 8'h00);
			chk(8'(o_route.use_bandgap), 8'(d[7:5] == SRC_BANDGAP));
			wr(ADDR_BANDGAP, d);
			rd(ADDR_BANDGAP, {7'h00, d[0]});
		end
		for (int k = 0; k < 8; k++) begin
			conv(k, 1'(k >> 1), (k < 4) ? 1'(k) : 1'($urandom));
		end
		// Result writes, a held start level and a start while off must all leave no trace.
		wr(ADDR_RESULT_LOW, ~e[7:0]);
		wr(ADDR_CTRL_START, 8'hA0);
		wr(ADDR_CTRL_START, 8'hA0);
		repeat (4) @(posedge i_ref_clk);
		#1;
		chk({7'h00, o_busy}, 8'h00);
		// Alignment goes back to one so the stored result is read in the same layout.
		wr(ADDR_CTRL_START, 8'h90);
		wr(ADDR_CTRL_START, 8'h10);
		repeat (4) @(posedge i_ref_clk);
		#1;
		chk({7'h00, o_busy}, 8'h00);
		rd(ADDR_RESULT_HIGH, e[15:8]);
		rd(ADDR_RESULT_LOW, e[7:0]);
		final_report();
	end
endmodule : sarc_ctrl_tb_top
